//--- msl_pkg.sv
`default_nettype none
package msl_pkg;
  // Clock and timing
  localparam int CLK_HZ = 40000000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int RSP_DLY_NS = 800000;
  localparam int RSP_DLY_CYC_DEF =
    (RSP_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BAUD_9600 = 9600;
  localparam int BAUD_19200 = 19200;
  localparam int BAUD_38400 = 38400;
  localparam int BAUD_57600 = 57600;
  localparam int BAUD_115200 = 115200;
  localparam int DIV_W = 16;
  localparam logic [3:0] LAST_RX_SAMPLE = 4'h9;
  localparam logic [3:0] LAST_TX_BIT = 4'hA;

  // Control and character codes
  localparam logic [7:0] C_SOH = 8'h01;
  localparam logic [7:0] C_STX = 8'h02;
  localparam logic [7:0] C_ETX = 8'h03;
  localparam logic [7:0] C_EOT = 8'h04;
  localparam logic [7:0] C_BCAST = 8'h2A;
  localparam logic [7:0] C_DIG0 = 8'h30;
  localparam logic [7:0] C_DIG9 = 8'h39;
  localparam logic [7:0] C_LETA = 8'h41;
  localparam logic [7:0] C_LETF = 8'h46;
  localparam logic [7:0] C_LETV = 8'h56;
  localparam logic [7:0] C_PRN_LO = 8'h20;
  localparam logic [7:0] C_PRN_HI = 8'h7E;
  localparam logic [7:0] C_CASE = 8'h20;
  localparam logic [4:0] DEC_TEN = 5'h0A;
  localparam logic [4:0] STN_ZERO = 5'h00;

  // Reply codes
  localparam logic [7:0] CODE_OK = 8'h41;
  localparam logic [7:0] CODE_PARITY = 8'h42;
  localparam logic [7:0] CODE_CHKSUM = 8'h43;
  localparam logic [7:0] CODE_CHAR = 8'h44;
  localparam logic [7:0] CODE_CMD = 8'h45;

  // Register map and fields
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_CONFIG = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam int CTRL_ALARM_BIT = 0;
  localparam int CFG_BAUD_LSB = 0;
  localparam int CFG_DLY_BIT = 3;
  localparam int CFG_STN_LSB = 4;
  localparam int CFG_USB_BIT = 9;
  localparam int ST_CODE_LSB = 0;
  localparam int ST_CNT_LSB = 8;
  localparam int ST_BUSY_BIT = 16;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_STN = 4'h1, ST_CMD1 = 4'h2, ST_CMD2 = 4'h3,
    ST_BODY = 4'h4, ST_CHK1 = 4'h5, ST_CHK2 = 4'h6, ST_DELAY = 4'h7,
    ST_TSTX = 4'h8, ST_TSTN = 4'h9, ST_TCODE = 4'hA, ST_TDATA = 4'hB,
    ST_TETX = 4'hC, ST_TCK1 = 4'hD, ST_TCK2 = 4'hE, ST_TEND = 4'hF
  } msl_state_type;

  typedef enum logic [1:0] {
    RX_IDLE = 2'h0, RX_START = 2'h1, RX_DATA = 2'h2
  } msl_rx_state_type;

  typedef enum logic {
    TX_IDLE = 1'h0, TX_SEND = 1'h1
  } msl_tx_state_type;

  function automatic logic [DIV_W-1:0] baud_div(input logic [2:0] sel);
    int b;
    case (sel)
      3'h1: b = BAUD_19200;
      3'h2: b = BAUD_38400;
      3'h3: b = BAUD_57600;
      3'h4: b = BAUD_115200;
      default: b = BAUD_9600;
    endcase
    return DIV_W'((CLK_HZ + b / 2) / b);
  endfunction : baud_div
endpackage : msl_pkg
`default_nettype wire

//--- msl_uart_if.sv
`default_nettype none
interface msl_uart_if;
  logic [15:0] div;
  logic rx_en;
  logic rx_valid;
  logic [7:0] rx_char;
  logic rx_err;
  logic tx_valid;
  logic [7:0] tx_char;
  logic tx_ready;
  logic tx_hold;
  modport phy (
    input div, rx_en, tx_valid, tx_char, tx_hold,
    output rx_valid, rx_char, rx_err, tx_ready
  );
  modport ctl (
    output div, rx_en, tx_valid, tx_char, tx_hold,
    input rx_valid, rx_char, rx_err, tx_ready
  );
endinterface : msl_uart_if
`default_nettype wire

//--- msl_uart_phy.sv
`default_nettype none
module msl_uart_phy (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic rxd,
  output logic txd,
  output logic tx_oe_n,
  msl_uart_if.phy u
);
  typedef struct packed {
    msl_pkg::msl_rx_state_type rs;
    logic [15:0] rcnt;
    logic [3:0] rbit;
    logic [9:0] rsh;
    logic rvalid;
    logic [7:0] rchar;
    logic rerr;
    msl_pkg::msl_tx_state_type ts;
    logic [15:0] tcnt;
    logic [3:0] tbit;
    logic [10:0] tsh;
    logic txd_low;
    logic drive;
  } msl_phy_state_type;

  msl_phy_state_type q;
  msl_phy_state_type n;
  logic [9:0] sh;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = q;
    sh = {rxd, q.rsh[9:1]};
    n.rvalid = 1'b0;
    case (q.rs)
      msl_pkg::RX_IDLE: begin
        if (u.rx_en && !rxd) begin
          n.rs = msl_pkg::RX_START;
          n.rcnt = u.div >> 1;
        end
      end
      msl_pkg::RX_START: begin
        if (q.rcnt != 16'h0000) begin
          n.rcnt = q.rcnt - 16'h0001;
        end else if (!rxd) begin
          n.rs = msl_pkg::RX_DATA;
          n.rcnt = u.div - 16'h0001;
          n.rbit = 4'h0;
        end else begin
          // Glitch, not a start bit
          n.rs = msl_pkg::RX_IDLE;
        end
      end
      msl_pkg::RX_DATA: begin
        if (q.rcnt != 16'h0000) begin
          n.rcnt = q.rcnt - 16'h0001;
        end else begin
          n.rsh = sh;
          n.rbit = q.rbit + 4'h1;
          n.rcnt = u.div - 16'h0001;
          if (q.rbit == msl_pkg::LAST_RX_SAMPLE) begin
            n.rs = msl_pkg::RX_IDLE;
            n.rvalid = 1'b1;
            n.rchar = sh[7:0];
            n.rerr = !sh[9] || (^sh[8:0]);
          end
        end
      end
      default: n.rs = msl_pkg::RX_IDLE;
    endcase
    case (q.ts)
      msl_pkg::TX_IDLE: begin
        if (u.tx_valid) begin
          n.ts = msl_pkg::TX_SEND;
          n.tsh = {1'b1, ^u.tx_char, u.tx_char, 1'b0};
          n.tcnt = u.div - 16'h0001;
          n.tbit = 4'h0;
        end
      end
      msl_pkg::TX_SEND: begin
        if (q.tcnt != 16'h0000) begin
          n.tcnt = q.tcnt - 16'h0001;
        end else begin
          n.tsh = {1'b1, q.tsh[10:1]};
          n.tbit = q.tbit + 4'h1;
          n.tcnt = u.div - 16'h0001;
          if (q.tbit == msl_pkg::LAST_TX_BIT) begin
            n.ts = msl_pkg::TX_IDLE;
          end
        end
      end
      default: n.ts = msl_pkg::TX_IDLE;
    endcase
    n.txd_low = (n.ts == msl_pkg::TX_SEND) && !n.tsh[0];
    // Driver drops as soon as the stop bit ends unless more follows
    n.drive = (n.ts == msl_pkg::TX_SEND) || u.tx_hold;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign u.rx_valid = q.rvalid;
  assign u.rx_char = q.rchar;
  assign u.rx_err = q.rerr;
  assign u.tx_ready = (q.ts == msl_pkg::TX_IDLE);
  assign txd = !q.txd_low;
  assign tx_oe_n = !q.drive;
endmodule : msl_uart_phy
`default_nettype wire

//--- msl_link.sv
// Function
// - Link runs at one selectable rate: 9600 to 115200 baud.
// - Character: start, eight data, even parity, one stop bit.
// - Half duplex: only one party drives the pair at a time.
// - Reply only after a received instruction frame, never unsolicited.
// - Delay setting 0 replies under 800 us, 1 waits 800 us or more.
// - Baud, delay and station settings take effect only after reset.
// - Station number ranges 0 to 31.
// - Act only on frames whose station field matches our station.
// - Asterisk station field addresses every device.
// - Broadcast reply comes only from station 0.
// - Reply carries one error code; anything but A is negative.
// - Frames open with SOH 01H or STX 02H.
// - Text closes with ETX 03H, then checksum characters.
// - EOT 04H resets the communication state.
// - Only one of serial or USB port is active at a time.
// - Data field length comes from the command.
// - Station character: 0-9 are 0-9, A-V are 10-31.
// - Checksum: low byte of sum after opener through ETX, two hex.
// - Error code upper case when normal, lower case in alarm.
//
// Local design decisions: the placing of the registers and the plain strobed port.
`default_nettype none
module msl_link #(
  parameter int RSP_DLY_CYC = msl_pkg::RSP_DLY_CYC_DEF
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic rxd,
  output logic txd,
  output logic tx_oe_n,
  input wire logic [2:0] cfg_baud_sel,
  input wire logic cfg_rsp_dly,
  input wire logic [4:0] cfg_station,
  input wire logic cfg_usb_sel,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic frm_valid,
  output logic frm_bad,
  output logic frm_bcast,
  output logic [15:0] frm_cmd,
  input wire logic [7:0] cmd_data_len,
  output logic dat_valid,
  output logic [7:0] dat_char,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_char,
  input wire logic rsp_last,
  output logic rsp_ready
);
  typedef struct packed {
    msl_pkg::msl_state_type st;
    logic cfg_ok;
    logic [2:0] baud;
    logic dly;
    logic [4:0] stn;
    logic usb;
    logic alarm;
    logic [15:0] div;
    logic [15:0] cnt;
    logic [7:0] sum;
    logic [7:0] chk_hi;
    logic fstn_ok;
    logic fbcast;
    logic par_err;
    logic chr_err;
    logic [15:0] cmd;
    logic [7:0] len;
    logic [7:0] code;
    logic good;
    logic [7:0] fcnt;
    logic [31:0] rdata;
    logic frm_valid;
    logic frm_bad;
    logic dat_valid;
    logic [7:0] dat_char;
  } msl_link_state_type;

  msl_link_state_type q;
  msl_link_state_type n;
  msl_uart_if u ();
  logic tx_fire;
  logic [7:0] tx_ch;
  logic sending;

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [4:0] hex_val(input logic [7:0] c);
    if (c >= msl_pkg::C_DIG0 && c <= msl_pkg::C_DIG9) begin
      return {1'b1, c[3:0]};
    end else if (c >= msl_pkg::C_LETA && c <= msl_pkg::C_LETF) begin
      return {1'b1, c[3:0] + 4'h9};
    end
    return 5'h00;
  endfunction : hex_val

  // Station and hex digits share one 0-9, A-V alphabet
  function automatic logic [7:0] char_of(input logic [4:0] v);
    if (v < msl_pkg::DEC_TEN) begin
      return msl_pkg::C_DIG0 + {3'h0, v};
    end
    return msl_pkg::C_LETA + {3'h0, v - msl_pkg::DEC_TEN};
  endfunction : char_of

  function automatic logic [5:0] stn_dec(input logic [7:0] c);
    if (c >= msl_pkg::C_DIG0 && c <= msl_pkg::C_DIG9) begin
      return {1'b1, 5'(c - msl_pkg::C_DIG0)};
    end else if (c >= msl_pkg::C_LETA && c <= msl_pkg::C_LETV) begin
      return {1'b1, 5'(c - msl_pkg::C_LETA) + msl_pkg::DEC_TEN};
    end
    return 6'h00;
  endfunction : stn_dec

  function automatic logic printable(input logic [7:0] c);
    return c >= msl_pkg::C_PRN_LO && c <= msl_pkg::C_PRN_HI;
  endfunction : printable

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [7:0] c;
    logic [4:0] hv_hi;
    logic [4:0] hv_lo;
    logic [5:0] sd;
    logic [7:0] code;
    c = u.rx_char;
    hv_hi = hex_val(q.chk_hi);
    hv_lo = hex_val(c);
    sd = stn_dec(c);
    code = msl_pkg::CODE_OK;
    n = q;
    n.frm_valid = 1'b0;
    n.frm_bad = 1'b0;
    n.dat_valid = 1'b0;
    rsp_ready = 1'b0;

    // Settings are sampled once after reset and never again
    if (!q.cfg_ok) begin
      n.cfg_ok = 1'b1;
      n.baud = cfg_baud_sel;
      n.div = msl_pkg::baud_div(cfg_baud_sel);
      n.dly = cfg_rsp_dly;
      n.stn = cfg_station;
      n.usb = cfg_usb_sel;
    end

    if (reg_wr && reg_addr == msl_pkg::REG_CTRL) begin
      n.alarm = reg_wdata[msl_pkg::CTRL_ALARM_BIT];
    end
    n.rdata = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        msl_pkg::REG_CTRL: n.rdata[msl_pkg::CTRL_ALARM_BIT] = q.alarm;
        msl_pkg::REG_CONFIG: begin
          n.rdata[msl_pkg::CFG_BAUD_LSB +: 3] = q.baud;
          n.rdata[msl_pkg::CFG_DLY_BIT] = q.dly;
          n.rdata[msl_pkg::CFG_STN_LSB +: 5] = q.stn;
          n.rdata[msl_pkg::CFG_USB_BIT] = q.usb;
        end
        msl_pkg::REG_STATUS: begin
          n.rdata[msl_pkg::ST_CODE_LSB +: 8] = q.code;
          n.rdata[msl_pkg::ST_CNT_LSB +: 8] = q.fcnt;
          n.rdata[msl_pkg::ST_BUSY_BIT] = (q.st != msl_pkg::ST_IDLE);
        end
        default: ;
      endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive side, parse one character per strobe
    if (u.rx_valid) begin
      if (!u.rx_err && c == msl_pkg::C_EOT) begin
        n.st = msl_pkg::ST_IDLE;
      end else begin
        if (u.rx_err && q.st != msl_pkg::ST_IDLE) begin
          n.par_err = 1'b1;
        end
        case (q.st)
          msl_pkg::ST_IDLE: begin
            if (!u.rx_err &&
                (c == msl_pkg::C_SOH || c == msl_pkg::C_STX)) begin
              n.st = msl_pkg::ST_STN;
              n.sum = 8'h00;
              n.len = 8'h00;
              n.par_err = 1'b0;
              n.chr_err = 1'b0;
            end
          end
          msl_pkg::ST_STN: begin
            n.sum = q.sum + c;
            n.fbcast = (c == msl_pkg::C_BCAST);
            n.fstn_ok = sd[5] && sd[4:0] == q.stn;
            n.st = msl_pkg::ST_CMD1;
          end
          msl_pkg::ST_CMD1, msl_pkg::ST_CMD2: begin
            n.sum = q.sum + c;
            n.chr_err = q.chr_err | !printable(c);
            if (q.st == msl_pkg::ST_CMD1) begin
              n.cmd[15:8] = c;
              n.st = msl_pkg::ST_CMD2;
            end else begin
              n.cmd[7:0] = c;
              n.st = msl_pkg::ST_BODY;
            end
          end
          msl_pkg::ST_BODY: begin
            n.sum = q.sum + c;
            if (c == msl_pkg::C_ETX) begin
              n.st = msl_pkg::ST_CHK1;
            end else if (c != msl_pkg::C_STX) begin
              n.len = q.len + 8'h01;
              n.chr_err = q.chr_err | !printable(c);
              n.dat_valid = q.fstn_ok | q.fbcast;
              n.dat_char = c;
            end
          end
          msl_pkg::ST_CHK1: begin
            n.chk_hi = c;
            n.st = msl_pkg::ST_CHK2;
          end
          msl_pkg::ST_CHK2: begin
            if (q.par_err || u.rx_err) begin
              code = msl_pkg::CODE_PARITY;
            end else if (!hv_hi[4] || !hv_lo[4] ||
                         {hv_hi[3:0], hv_lo[3:0]} != q.sum) begin
              code = msl_pkg::CODE_CHKSUM;
            end else if (q.chr_err) begin
              code = msl_pkg::CODE_CHAR;
            end else if (q.len != cmd_data_len) begin
              code = msl_pkg::CODE_CMD;
            end
            n.good = (code == msl_pkg::CODE_OK);
            n.code = q.alarm ? (code | msl_pkg::C_CASE) : code;
            if (q.fstn_ok || q.fbcast) begin
              n.frm_valid = n.good;
              n.frm_bad = !n.good;
              if (n.good) begin
                n.fcnt = q.fcnt + 8'h01;
              end
            end
            // Broadcast is acted on by all but answered by station 0
            if (q.fstn_ok || (q.fbcast && q.stn == msl_pkg::STN_ZERO)) begin
              n.st = msl_pkg::ST_DELAY;
              n.cnt = q.dly ? 16'(RSP_DLY_CYC - 1) : q.div;
            end else begin
              n.st = msl_pkg::ST_IDLE;
            end
          end
          default: ;
        endcase
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reply side
    case (q.st)
      msl_pkg::ST_TSTX: tx_ch = msl_pkg::C_STX;
      msl_pkg::ST_TSTN: tx_ch = char_of(q.stn);
      msl_pkg::ST_TCODE: tx_ch = q.code;
      msl_pkg::ST_TDATA: tx_ch = rsp_char;
      msl_pkg::ST_TETX: tx_ch = msl_pkg::C_ETX;
      msl_pkg::ST_TCK1: tx_ch = char_of({1'b0, q.sum[7:4]});
      msl_pkg::ST_TCK2: tx_ch = char_of({1'b0, q.sum[3:0]});
      default: tx_ch = 8'h00;
    endcase
    sending = q.st >= msl_pkg::ST_TSTX && q.st <= msl_pkg::ST_TCK2;
    tx_fire = sending && u.tx_ready &&
              (q.st != msl_pkg::ST_TDATA || rsp_valid);
    if (q.st == msl_pkg::ST_DELAY) begin
      if (q.cnt != 16'h0000) begin
        n.cnt = q.cnt - 16'h0001;
      end else begin
        n.st = msl_pkg::ST_TSTX;
      end
    end
    if (tx_fire) begin
      if (q.st == msl_pkg::ST_TSTX) begin
        n.sum = 8'h00;
      end else if (q.st <= msl_pkg::ST_TETX) begin
        n.sum = q.sum + tx_ch;
      end
      case (q.st)
        msl_pkg::ST_TCODE: begin
          // Negative replies carry no data
          n.st = (q.good && rsp_valid) ? msl_pkg::ST_TDATA
                                       : msl_pkg::ST_TETX;
        end
        msl_pkg::ST_TDATA: begin
          rsp_ready = 1'b1;
          if (rsp_last) begin
            n.st = msl_pkg::ST_TETX;
          end
        end
        default: n.st = msl_pkg::msl_state_type'(q.st + 4'h1);
      endcase
    end
    if (q.st == msl_pkg::ST_TEND && u.tx_ready) begin
      n.st = msl_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receiver is deaf while replying and when USB owns the host link
  assign u.rx_en = q.cfg_ok && !q.usb && q.st < msl_pkg::ST_DELAY;
  assign u.div = q.div;
  assign u.tx_valid = tx_fire;
  assign u.tx_char = tx_ch;
  assign u.tx_hold = sending;

  msl_uart_phy i_phy (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .rxd(rxd),
    .txd(txd),
    .tx_oe_n(tx_oe_n),
    .u(u.phy)
  );

  assign reg_rdata = q.rdata;
  assign frm_valid = q.frm_valid;
  assign frm_bad = q.frm_bad;
  assign frm_bcast = q.fbcast;
  assign frm_cmd = q.cmd;
  assign dat_valid = q.dat_valid;
  assign dat_char = q.dat_char;
endmodule : msl_link
`default_nettype wire

//--- msl_link_monitor.sv
`default_nettype none
module msl_link_monitor #(
  parameter int RSP_DLY_CYC = 32000
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic txd,
  input wire logic tx_oe_n,
  input wire logic [2:0] cfg_baud_sel,
  input wire logic cfg_rsp_dly,
  input wire logic [4:0] cfg_station,
  input wire logic cfg_usb_sel,
  input wire logic [3:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic frm_valid,
  input wire logic frm_bad
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SHORT_MAX = 32000;
  logic armed_q;
  logic seen_q;
  logic [9:0] cfg_q;
  int gap_q;
  // Settings as latched on the first edge after reset
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      armed_q <= 1'b0;
      seen_q <= 1'b0;
      cfg_q <= '0;
      gap_q <= 0;
    end else begin
      seen_q <= 1'b1;
      if (!seen_q) begin
        cfg_q <= {cfg_usb_sel, cfg_station, cfg_rsp_dly, cfg_baud_sel};
      end
      if (frm_valid || frm_bad) begin
        armed_q <= 1'b1;
        gap_q <= 0;
      end else begin
        if (!tx_oe_n) begin
          armed_q <= 1'b0;
        end
        if (gap_q < SHORT_MAX) begin
          gap_q <= gap_q + 1;
        end
      end
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////
  property p_start_bit;
    $fell(tx_oe_n) |-> !txd ##1 (!txd) [*8];
  endproperty
  a_start_bit: assert property (p_start_bit)
    else $error("reply did not open with a start bit");
  property p_idle_high;
    tx_oe_n |-> txd;
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("released line not at idle level");
  property p_solicited;
    $fell(tx_oe_n) |-> armed_q;
  endproperty
  a_solicited: assert property (p_solicited)
    else $error("transmitter enabled without a received frame");
  property p_long_gap;
    $fell(tx_oe_n) && cfg_q[3] |-> gap_q + 2 >= RSP_DLY_CYC;
  endproperty
  a_long_gap: assert property (p_long_gap)
    else $error("reply came before the long gap");
  property p_short_gap;
    $fell(tx_oe_n) && !cfg_q[3] |-> gap_q < SHORT_MAX;
  endproperty
  a_short_gap: assert property (p_short_gap)
    else $error("short gap reply too late");
  property p_usb_dead;
    cfg_q[9] |-> tx_oe_n && !frm_valid && !frm_bad;
  endproperty
  a_usb_dead: assert property (p_usb_dead)
    else $error("serial port active while usb owns the link");
  property p_cfg_frozen;
    $past(reg_rd) && $past(reg_addr) == 4'h4 |-> reg_rdata[9:0] == cfg_q;
  endproperty
  a_cfg_frozen: assert property (p_cfg_frozen)
    else $error("settings changed without reset");
  property p_pulse_once;
    frm_valid |-> !frm_bad ##1 !frm_valid;
  endproperty
  a_pulse_once: assert property (p_pulse_once)
    else $error("frame verdict not a single clean pulse");
endmodule : msl_link_monitor
bind msl_link msl_link_monitor #(.RSP_DLY_CYC(RSP_DLY_CYC)) mon (
  .ref_clk(ref_clk), .reset_n(reset_n), .txd(txd), .tx_oe_n(tx_oe_n),
  .cfg_baud_sel(cfg_baud_sel), .cfg_rsp_dly(cfg_rsp_dly),
  .cfg_station(cfg_station), .cfg_usb_sel(cfg_usb_sel),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .frm_valid(frm_valid), .frm_bad(frm_bad)
);
`default_nettype wire

//--- msl_master_model.sv
`default_nettype none
module msl_master_model #(
  parameter int BIT_CYC = 347 // Same rate as the device
) (
  input wire logic ref_clk,
  input wire logic txd,
  input wire logic tx_oe_n,
  output var logic rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx_q[$];
  int rx_err;
  wire logic line;
  // Released pair sits at mark through the bias network
  assign line = tx_oe_n ? 1'b1 : txd;
  initial begin
    rxd = 1'b1;
    rx_err = 0;
  end
  function automatic logic [7:0] hex(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction : hex
  task automatic send_char(input logic [7:0] c);
    logic [10:0] f;
    f = {1'b1, ^c, c, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd <= f[i];
      repeat (BIT_CYC) @(posedge ref_clk);
    end
  endtask : send_char
  // One fresh request per reading, no data field
  task automatic send_frame(input logic [7:0] stn, c1, c2);
    logic [7:0] s;
    wait (tx_oe_n === 1'b1);
    @(posedge ref_clk);
    s = stn + c1 + c2 + 8'h03;
    send_char(8'h02);
    send_char(stn);
    send_char(c1);
    send_char(c2);
    send_char(8'h03);
    send_char(hex(s[7:4]));
    send_char(hex(s[3:0]));
  endtask : send_frame
  always begin
    logic [10:0] f;
    @(negedge line);
    repeat (BIT_CYC / 2) @(posedge ref_clk);
    for (int i = 0; i < 11; i++) begin
      f[i] = line;
      if (i < 10) repeat (BIT_CYC) @(posedge ref_clk);
    end
    if (!f[0] && f[10] && !(^f[9:1])) rx_q.push_back(f[8:1]);
    else rx_err++;
  end
endmodule : msl_master_model
`default_nettype wire

//--- msl_link_test.sv
`default_nettype none
`define CHK(a, e) begin \
  check_count++; \
  if ((a) !== (e)) begin \
    miscompares++; \
    $display("[FAIL] t=%0t got %0h exp %0h", $time, (a), (e)); \
  end \
end
module msl_link_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT_CYC = (40000000 + 115200 / 2) / 115200;
  typedef struct {logic [3:0] addr; logic [31:0] exp;} msl_row_type;
  msl_row_type rows [4] = '{'{4'h0, 32'h0}, '{4'h4, 32'h5C},
    '{4'hC, 32'h0}, '{4'h2, 32'h0}};
  logic ref_clk, reset_n, rxd, txd, tx_oe_n, cfg_rsp_dly, cfg_usb_sel;
  logic [2:0] cfg_baud_sel;
  logic [4:0] cfg_station;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd;
  logic reg_wr, reg_rd, frm_valid, frm_bad, frm_bcast, dat_valid, rsp_ready;
  logic [15:0] frm_cmd;
  logic [7:0] dat_char;
  int miscompares = 0;
  int check_count = 0;
  int good_cnt = 0;
  msl_link #(.RSP_DLY_CYC(50)) uut (.ref_clk(ref_clk), .reset_n(reset_n),
    .rxd(rxd), .txd(txd), .tx_oe_n(tx_oe_n), .cfg_baud_sel(cfg_baud_sel),
    .cfg_rsp_dly(cfg_rsp_dly), .cfg_station(cfg_station),
    .cfg_usb_sel(cfg_usb_sel), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .frm_valid(frm_valid), .frm_bad(frm_bad), .frm_bcast(frm_bcast),
    .frm_cmd(frm_cmd), .cmd_data_len(8'h00), .dat_valid(dat_valid),
    .dat_char(dat_char), .rsp_valid(1'b0), .rsp_char(8'h00),
    .rsp_last(1'b0), .rsp_ready(rsp_ready));
  msl_master_model #(.BIT_CYC(BIT_CYC)) master (.ref_clk(ref_clk),
    .txd(txd), .tx_oe_n(tx_oe_n), .rxd(rxd));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Sampled mid-cycle so the pulse is seen once, settled
  always @(negedge ref_clk) if (frm_valid === 1'b1) good_cnt++;
  ////////////////////////////////////////////////////////////////////////////
  task automatic do_reset(input logic [4:0] stn, input logic dly, usb);
    @(posedge ref_clk);
    reset_n <= 1'b0;
    cfg_station <= stn;
    cfg_rsp_dly <= dly;
    cfg_usb_sel <= usb;
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
  endtask : do_reset
  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask : reg_read
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  task automatic check_reply(input logic [7:0] stn, code);
    logic [7:0] e [6];
    logic [7:0] s;
    s = stn + code + 8'h03;
    e = '{8'h02, stn, code, 8'h03, master.hex(s[7:4]), master.hex(s[3:0])};
    for (int n = 0; n < 30000 && master.rx_q.size() < 6; n++)
      @(posedge ref_clk);
    repeat (BIT_CYC) @(posedge ref_clk);
    `CHK(master.rx_q.size(), 6)
    `CHK(tx_oe_n, 1'b1)
    `CHK(master.rx_err, 0)
    if (master.rx_q.size() == 6) begin
      for (int i = 0; i < 6; i++) `CHK(master.rx_q[i], e[i])
    end
    master.rx_q.delete();
  endtask : check_reply
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  initial begin
    repeat (180000) @(posedge ref_clk);
    miscompares++;
    end_sim;
  end
  initial begin
    reset_n = 1'b0;
    cfg_baud_sel = 3'h4;
    cfg_rsp_dly = 1'b1;
    cfg_station = 5'h05;
    cfg_usb_sel = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    do_reset(5'h05, 1'b1, 1'b0);
    for (int i = 0; i < 4; i++) begin
      reg_read(rows[i].addr, rd);
      `CHK(rd, rows[i].exp)
    end
    $display("register rows done");
    master.send_frame(8'h35, 8'h30, 8'h31);
    check_reply(8'h35, 8'h41);
    `CHK(good_cnt, 1)
    `CHK(frm_cmd, 16'h3031)
    `CHK(frm_bcast, 1'b0)
    reg_read(4'h8, rd);
    `CHK(rd[16:0], 17'h00141)
    @(posedge ref_clk);
    cfg_station <= 5'h00;
    cfg_rsp_dly <= 1'b0;
    reg_write(4'h4, 32'hFFFFFFFF);
    reg_read(4'h4, rd);
    `CHK(rd, 32'h5C)
    $display("own station frame done");
    do_reset(5'h00, 1'b0, 1'b0);
    reg_read(4'h4, rd);
    `CHK(rd, 32'h04)
    reg_write(4'h0, 32'h1);
    reg_read(4'h0, rd);
    `CHK(rd, 32'h1)
    master.send_frame(8'h33, 8'h30, 8'h31);
    repeat (3 * BIT_CYC) @(posedge ref_clk);
    `CHK(master.rx_q.size(), 0)
    `CHK(tx_oe_n, 1'b1)
    `CHK(good_cnt, 1)
    // Cut frame abandoned by the master's recovery character
    master.send_char(8'h02);
    master.send_char(8'h30);
    master.send_char(8'h04);
    reg_read(4'h8, rd);
    `CHK(rd[16], 1'b0)
    `CHK(tx_oe_n, 1'b1)
    $display("recovery character done");
    master.send_frame(8'h2A, 8'h30, 8'h31);
    check_reply(8'h30, 8'h61);
    `CHK(frm_bcast, 1'b1)
    `CHK(good_cnt, 2)
    $display("broadcast frame done");
    do_reset(5'h00, 1'b0, 1'b1);
    reg_read(4'h4, rd);
    `CHK(rd, 32'h204)
    `CHK(tx_oe_n, 1'b1)
    $display("usb select done");
    end_sim;
  end
endmodule : msl_link_test
`default_nettype wire
